// ==== shared/startup_id_map.svh ====
/*
 Offsets, field positions and reset values of the startup and identity register bank.
 Assumes byte-wide registers reached at their printed offsets over the serial control port.
*/
`ifndef STARTUP_ID_MAP_SVH
`define STARTUP_ID_MAP_SVH
`define ADDR_WIDTH 10
`define OFF_STARTUP_BOOT_CONTROL 10'h000
`define OFF_BOOT_MEMORY_ADDRESS 10'h001
`define OFF_IDENTITY_BYTE_0 10'h002
`define OFF_IDENTITY_BYTE_3 10'h005
`define OFF_SERIAL_IF_FIRST 10'h006
`define OFF_STARTUP_LAST 10'h001
`define OFF_IDENTITY_LAST 10'h005
`define OFF_SERIAL_IF_LAST 10'h007
`define OFF_PLL0_LAST 10'h03A
`define OFF_PLL1_LAST 10'h06D
`define OFF_GPIO_LAST 10'h076
`define OFF_OUTPUT_LAST 10'h0AB
`define OFF_APLL0_LAST 10'h0AF
`define OFF_APLL1_LAST 10'h0B3
`define OFF_POWER_LAST 10'h0B8
`define OFF_MONITOR_LAST 10'h0C6
`define OFF_IRQ_ENABLE_LAST 10'h0C8
`define OFF_STATUS_FIRST 10'h200
`define OFF_STATUS_LAST 10'h21F
`define OFF_SPACE_LAST 10'h3FF
`define RETRY_COUNT_RESET 5'h01
`define RETRY_LSB 3
`define INTERNAL_BOOT_BIT 1
`define EXTERNAL_BOOT_BIT 0
`define WIDE_OFFSET_BIT 7
`define SLAVE_ADDR_MSB 6
`endif

// ==== shared/startup_id_pkg.sv ====
/*
 Types shared by the startup and identity register bank.
 Assumes the map header is included by the files that need offsets.
*/
package startup_id_pkg;
	typedef enum logic [1:0] {
		PORT_BLOCKED = 2'b00,
		PORT_OPEN = 2'b01
	} port_state_t;

	typedef enum logic [3:0] {
		BLK_STARTUP = 4'h0,
		BLK_IDENTITY = 4'h1,
		BLK_SERIAL_IF = 4'h2,
		BLK_PLL0 = 4'h3,
		BLK_PLL1 = 4'h4,
		BLK_GPIO = 4'h5,
		BLK_OUTPUT = 4'h6,
		BLK_APLL0 = 4'h7,
		BLK_APLL1 = 4'h8,
		BLK_POWER = 4'h9,
		BLK_MONITOR = 4'hA,
		BLK_IRQ_ENABLE = 4'hB,
		BLK_STATUS = 4'hC,
		BLK_RESERVED = 4'hF
	} block_sel_t;

	typedef struct packed {
		logic [4:0] boot_retry_count;
		logic internal_boot_disable_n;
		logic external_boot_disable_n;
		logic wide_offset_select;
		logic [6:0] boot_memory_slave_address;
	} boot_config_t;

	typedef struct packed {
		logic [3:0] revision_field;
		logic [15:0] part_code_field;
		logic [10:0] variant_code;
	} identity_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [9:0] addr;
		logic [7:0] wdata;
	} reg_access_t;
endpackage

// ==== rtl/block_decoder.sv ====
/*
 Sorts a register offset into the block that owns it.
 Assumes a ten-bit offset from the serial control port.
*/
`timescale 1ns/100ps
`include "startup_id_map.svh"
module block_decoder (
	input wire logic [9:0] addr,
	output startup_id_pkg::block_sel_t block
);
	// Fixed block ranges; gaps up to the top of the space are reserved
	always_comb begin
		if (addr <= `OFF_STARTUP_LAST) block = startup_id_pkg::BLK_STARTUP;
		else if (addr <= `OFF_IDENTITY_LAST) block = startup_id_pkg::BLK_IDENTITY;
		else if (addr <= `OFF_SERIAL_IF_LAST) block = startup_id_pkg::BLK_SERIAL_IF;
		else if (addr <= `OFF_PLL0_LAST) block = startup_id_pkg::BLK_PLL0;
		else if (addr <= `OFF_PLL1_LAST) block = startup_id_pkg::BLK_PLL1;
		else if (addr <= `OFF_GPIO_LAST) block = startup_id_pkg::BLK_GPIO;
		else if (addr <= `OFF_OUTPUT_LAST) block = startup_id_pkg::BLK_OUTPUT;
		else if (addr <= `OFF_APLL0_LAST) block = startup_id_pkg::BLK_APLL0;
		else if (addr <= `OFF_APLL1_LAST) block = startup_id_pkg::BLK_APLL1;
		else if (addr <= `OFF_POWER_LAST) block = startup_id_pkg::BLK_POWER;
		else if (addr <= `OFF_MONITOR_LAST) block = startup_id_pkg::BLK_MONITOR;
		else if (addr <= `OFF_IRQ_ENABLE_LAST) block = startup_id_pkg::BLK_IRQ_ENABLE;
		else if (addr >= `OFF_STATUS_FIRST && addr <= `OFF_STATUS_LAST) begin
			block = startup_id_pkg::BLK_STATUS;
		end else block = startup_id_pkg::BLK_RESERVED;
	end
endmodule

// ==== rtl/startup_and_id_register_bank.sv ====
/*
 Startup control and identity registers with block decode of the full register space.
 Assumes a byte access strobe from the serial control port logic, factory values
 presented as inputs, and a boot engine outside that reports busy and failure.
*/
// Summary of operation
// - Offsets decode into fixed blocks and gaps up to 03FF are reserved.
// - A five-bit retry count sets extra arbitration attempts and resets to one.
// - Internal boot disable low loads all config from internal memory, high only eight bytes.
// - External boot disable low loads config from the EEPROM over internal values.
// - The wide offset select bit makes the boot reader use two-byte offsets.
// - Seven bits of the second startup register hold the EEPROM slave address.
// - Reserved bits are written as zero by software and read back as zero.
// - Port accesses are ignored while the external boot load runs.
// - A failed boot read or checksum aborts the boot and sets the failure flag.
`timescale 1ns/100ps
`include "startup_id_map.svh"
module startup_and_id_register_bank #(
	parameter logic [3:0] REVISION_DEFAULT = 4'h1, // Arbitrary value
	parameter logic [15:0] PART_CODE_DEFAULT = 16'h1234 // Arbitrary value
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_up_done,
	input startup_id_pkg::reg_access_t access,
	output logic [7:0] rdata,
	output logic access_taken,
	output startup_id_pkg::block_sel_t access_block,
	input startup_id_pkg::boot_config_t factory_boot,
	input wire logic [10:0] factory_variant,
	input wire logic boot_busy,
	input wire logic boot_abort,
	output startup_id_pkg::boot_config_t boot_config,
	output logic load_internal_full,
	output logic load_external,
	output logic two_byte_offset,
	output logic boot_failure_flag
);
	startup_id_pkg::boot_config_t cfg;
	startup_id_pkg::identity_t ident;
	startup_id_pkg::port_state_t port_state;
	logic factory_loaded;
	logic [7:0] next_rdata;
	wire logic port_open;
	wire logic wr_en;
	wire logic rd_en;
	wire logic sel_ctrl;
	wire logic sel_addr;
	wire logic sel_id0;
	wire logic sel_id1;
	wire logic sel_id2;
	wire logic sel_id3;

	block_decoder u_decode (
		.addr(access.addr),
		.block(access_block)
	);

	// Gate accesses while the boot load is active
	assign port_open = (port_state == startup_id_pkg::PORT_OPEN) && !boot_busy;
	assign wr_en = access.write && port_open;
	assign rd_en = access.read && port_open;
	assign access_taken = (access.write || access.read) && port_open;
	assign sel_ctrl = access.addr == `OFF_STARTUP_BOOT_CONTROL;
	assign sel_addr = access.addr == `OFF_BOOT_MEMORY_ADDRESS;
	assign sel_id0 = access.addr == `OFF_IDENTITY_BYTE_0;
	assign sel_id1 = access.addr == (`OFF_IDENTITY_BYTE_0 + 10'h001);
	assign sel_id2 = access.addr == (`OFF_IDENTITY_BYTE_0 + 10'h002);
	assign sel_id3 = access.addr == `OFF_IDENTITY_BYTE_3;

	// Boot steering outputs
	assign boot_config = cfg;
	assign load_internal_full = !cfg.internal_boot_disable_n;
	assign load_external = !cfg.external_boot_disable_n;
	assign two_byte_offset = cfg.wide_offset_select;

	// Read mux; reserved bit 2 of the control byte reads as zero
	always_comb begin
		next_rdata = 8'h00;
		if (sel_ctrl) begin
			next_rdata = {cfg.boot_retry_count, 1'b0, cfg.internal_boot_disable_n,
				cfg.external_boot_disable_n};
		end else if (sel_addr) begin
			next_rdata = {cfg.wide_offset_select, cfg.boot_memory_slave_address};
		end else if (sel_id0) begin
			next_rdata = {ident.revision_field, ident.part_code_field[15:12]};
		end else if (sel_id1) begin
			next_rdata = ident.part_code_field[11:4];
		end else if (sel_id2) begin
			next_rdata = {ident.part_code_field[3:0], ident.variant_code[10:7]};
		end else if (sel_id3) begin
			next_rdata = {ident.variant_code[6:0], 1'b0};
		end
	end

	// Read data register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rdata <= 8'h00;
		else if (rd_en) rdata <= next_rdata;
	end

	// Port opens after the power-up sequence has loaded factory values
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) port_state <= startup_id_pkg::PORT_BLOCKED;
		else begin
			case (port_state)
				startup_id_pkg::PORT_BLOCKED: begin
					if (factory_loaded) port_state <= startup_id_pkg::PORT_OPEN;
				end
				startup_id_pkg::PORT_OPEN: port_state <= startup_id_pkg::PORT_OPEN;
				default: port_state <= startup_id_pkg::PORT_BLOCKED;
			endcase
		end
	end

	// Startup registers: factory load once, then software writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg <= '0;
			cfg.boot_retry_count <= `RETRY_COUNT_RESET;
			cfg.internal_boot_disable_n <= 1'b1;
			cfg.external_boot_disable_n <= 1'b1;
			factory_loaded <= 1'b0;
		end else if (power_up_done && !factory_loaded) begin
			cfg <= factory_boot;
			cfg.boot_retry_count <= `RETRY_COUNT_RESET;
			factory_loaded <= 1'b1;
		end else if (wr_en && sel_ctrl) begin
			cfg.boot_retry_count <= access.wdata[7:`RETRY_LSB];
			cfg.internal_boot_disable_n <= access.wdata[`INTERNAL_BOOT_BIT];
			cfg.external_boot_disable_n <= access.wdata[`EXTERNAL_BOOT_BIT];
		end else if (wr_en && sel_addr) begin
			cfg.wide_offset_select <= access.wdata[`WIDE_OFFSET_BIT];
			cfg.boot_memory_slave_address <= access.wdata[`SLAVE_ADDR_MSB:0];
		end
	end

	// Identity registers: factory load once, then writable whenever the port is open
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ident <= '0;
		end else if (power_up_done && !factory_loaded) begin
			ident <= {REVISION_DEFAULT, PART_CODE_DEFAULT, factory_variant};
		end else if (wr_en && sel_id0) begin
			ident.revision_field <= access.wdata[7:4];
			ident.part_code_field[15:12] <= access.wdata[3:0];
		end else if (wr_en && sel_id1) begin
			ident.part_code_field[11:4] <= access.wdata;
		end else if (wr_en && sel_id2) begin
			ident.part_code_field[3:0] <= access.wdata[7:4];
			ident.variant_code[10:7] <= access.wdata[3:0];
		end else if (wr_en && sel_id3) begin
			ident.variant_code[6:0] <= access.wdata[7:1];
		end
	end

	// Sticky boot failure flag, only cleared by reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) boot_failure_flag <= 1'b0;
		else if (boot_abort) boot_failure_flag <= 1'b1;
	end
endmodule

// ==== verification/startup_and_id_register_bank_asserts.sv ====
/*
 Checker for the startup and identity register bank.
 Assumes it is bound to the bank's top module.
*/
`timescale 1ns/100ps
module startup_and_id_register_bank_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_up_done,
	input startup_id_pkg::reg_access_t access,
	input wire logic [7:0] rdata,
	input wire logic access_taken,
	input startup_id_pkg::block_sel_t access_block,
	input startup_id_pkg::boot_config_t factory_boot,
	input wire logic [10:0] factory_variant,
	input wire logic boot_busy,
	input wire logic boot_abort,
	input startup_id_pkg::boot_config_t boot_config,
	input wire logic load_internal_full,
	input wire logic load_external,
	input wire logic two_byte_offset,
	input wire logic boot_failure_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Port acceptance, field updates and boot outputs
	access_gate_a: assert property (
		access_taken |-> (access.write || access.read) && !boot_busy) else $error("bad accept");
	retry_write_a: assert property (
		access_taken && access.write && access.addr == 10'h000
		|=> boot_config.boot_retry_count == $past(access.wdata[7:3])) else $error("retry write");
	slave_write_a: assert property (
		access_taken && access.write && access.addr == 10'h001
		|=> {two_byte_offset, boot_config.boot_memory_slave_address} == $past(access.wdata))
		else $error("address write");
	reserved_decode_a: assert property (
		access.addr >= 10'h220 || (access.addr >= 10'h0C9 && access.addr <= 10'h1FF)
		|-> access_block == startup_id_pkg::BLK_RESERVED) else $error("reserved decode");
	factory_retry_a: assert property (
		$rose(power_up_done) |=> boot_config.boot_retry_count == 5'h01) else $error("retry reset");
	boot_mode_a: assert property (
		access_taken && access.write && access.addr == 10'h000
		|=> load_internal_full == !$past(access.wdata[1])
		&& load_external == !$past(access.wdata[0]))
		else $error("boot mode");
	flag_set_a: assert property (
		boot_abort |=> boot_failure_flag) else $error("flag not set");
	flag_sticky_a: assert property (
		boot_failure_flag |=> boot_failure_flag) else $error("flag dropped");
endmodule
bind startup_and_id_register_bank startup_and_id_register_bank_asserts chk (.*);

// ==== verification/startup_and_id_register_bank_bench.sv ====
/*
 Self-checking bench for the startup and identity register bank.
 Assumes the checker binds itself to the design.
*/
`timescale 1ns/100ps
module startup_and_id_register_bank_bench;
	logic clk = 0;
	logic resetn = 0;
	logic power_up_done = 0;
	startup_id_pkg::reg_access_t access = '0;
	logic [7:0] rdata;
	logic access_taken;
	startup_id_pkg::block_sel_t access_block;
	startup_id_pkg::boot_config_t factory_boot = {5'h00, 1'b1, 1'b0, 1'b1, 7'h50};
	logic [10:0] factory_variant = 11'h5A3;
	logic boot_busy = 0;
	logic boot_abort = 0;
	startup_id_pkg::boot_config_t boot_config;
	logic load_internal_full, load_external, two_byte_offset, boot_failure_flag;
	int failures = 0;
	int compares = 0;
	logic [9:0] at [18] = '{10'h001, 10'h005, 10'h007, 10'h03A, 10'h03B, 10'h076,
		10'h0AB, 10'h0AF, 10'h0B3, 10'h0B8, 10'h0C6, 10'h0C8, 10'h0C9, 10'h1FF,
		10'h200, 10'h21F, 10'h220, 10'h3FF};
	logic [3:0] bt [18] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
		4'hA, 4'hB, 4'hF, 4'hF, 4'hC, 4'hC, 4'hF, 4'hF};
	// Identity defaults fixed here so expected bytes do not lean on the design
	startup_and_id_register_bank #(
		.REVISION_DEFAULT(4'h1),
		.PART_CODE_DEFAULT(16'h1234)
	) DUT (.*);
	// Clock at 10 MHz
	always #50 clk = ~clk;
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle request; taken flag and read data looked at just after the edge
	task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d,
		input logic [7:0] exp, input logic [7:0] m, input logic tk);
		@(negedge clk);
		access = '{wr, !wr, a, d};
		@(posedge clk);
		#1;
		chk(8'(access_taken), 8'(tk));
		if (!wr)
			chk(rdata & m, exp);
		@(negedge clk);
		access = '0;
	endtask
	// Verdict and end of run
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1;
		acc(1, 10'h001, 8'h11, 0, 0, 0);
		@(negedge clk);
		power_up_done = 1;
		repeat (2) @(negedge clk);
		acc(0, 10'h000, 0, 8'h0A, 8'hFB, 1);
		acc(0, 10'h001, 0, 8'hD0, 8'hFF, 1);
		chk(8'({load_internal_full, load_external, two_byte_offset}), 8'h03);
		acc(0, 10'h002, 0, 8'h11, 8'hFF, 1);
		acc(0, 10'h003, 0, 8'h23, 8'hFF, 1);
		acc(0, 10'h004, 0, 8'h4B, 8'hFF, 1);
		acc(0, 10'h005, 0, 8'h46, 8'hFE, 1);
		chk(8'(boot_failure_flag), 8'h00);
		$display("Factory defaults test done");
		acc(1, 10'h000, 8'hF9, 0, 0, 1);
		acc(0, 10'h000, 0, 8'hF9, 8'hFB, 1);
		chk(8'({load_internal_full, load_external}), 8'h02);
		acc(1, 10'h001, 8'h2A, 0, 0, 1);
		acc(0, 10'h001, 0, 8'h2A, 8'hFF, 1);
		chk(8'(two_byte_offset), 8'h00);
		acc(1, 10'h005, 8'hFE, 0, 0, 1);
		acc(0, 10'h005, 0, 8'hFE, 8'hFE, 1);
		$display("Register write test done");
		for (int i = 0; i < 18; i++) begin
			@(negedge clk);
			access.addr = at[i];
			#1;
			chk(8'(access_block), 8'(bt[i]));
		end
		@(negedge clk);
		access = '0;
		boot_busy = 1;
		$display("Block decode test done");
		acc(1, 10'h001, 8'h11, 0, 0, 0);
		acc(0, 10'h000, 0, 8'hFE, 8'hFF, 0);
		boot_busy = 0;
		acc(0, 10'h001, 0, 8'h2A, 8'hFF, 1);
		$display("Busy refusal test done");
		boot_abort = 1;
		@(negedge clk);
		boot_abort = 0;
		repeat (3) @(negedge clk);
		chk(8'(boot_failure_flag), 8'h01);
		$display("Boot abort test done");
		resetn = 0;
		#1;
		chk(8'(boot_failure_flag), 8'h00);
		chk(8'(boot_config.boot_retry_count), 8'h01);
		repeat (2) @(negedge clk);
		resetn = 1;
		repeat (2) @(negedge clk);
		acc(0, 10'h001, 0, 8'hD0, 8'hFF, 1);
		acc(0, 10'h005, 0, 8'h46, 8'hFE, 1);
		$display("Mid-run reset test done");
		end_sim();
	end
endmodule
